// [design/eac_ctrl.sv]
// eeprom access control: i/o registers, armed write, reads, stalls and ready interrupt
`timescale 1ns/1ps
module eac_ctrl #(
  parameter int OSC_DIV    = eac_pkg::OSC_DIV,
  parameter int WR_OSC_CYC = eac_pkg::WR_OSC_CYC,
  parameter int DEPTH      = 2048
) (
  // clock and resets
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       por,
  // cpu i/o access
  input  wire logic [5:0] io_addr,
  input  wire logic       io_we,
  input  wire logic       io_re,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // cpu side status
  input  wire logic       global_irq_en,
  input  wire logic       flash_selfprog_busy,
  input  wire logic       sleep_pd_req,
  output logic            cpu_stall,
  output logic            ready_irq,
  // power management
  output logic            osc_run,
  output logic            pd_allowed
);
  typedef struct packed {
    logic                         ready_irq_enable;
    logic [2:0]                   arm_cnt;
    logic                         write_strobe;
    logic                         read_strobe;
    logic [eac_pkg::ADDR_W-1:0]   eeprom_addr_reg;
    logic [eac_pkg::DATA_W-1:0]   eeprom_data_reg;
    logic [eac_pkg::ADDR_W-1:0]   wr_addr;
    logic [eac_pkg::DATA_W-1:0]   wr_data;
    logic [2:0]                   stall;
    logic [7:0]                   rdata;
  } eac_state_t;

  eac_state_t st_ff;
  eac_state_t nxt_st;
  logic [7:0] mem [DEPTH];
  logic       tmr_busy;
  logic       tmr_done;
  logic       wr_start;
  logic       rd_go;
  logic       ctrl_wr;
  logic       master_write_arm;
  logic [7:0] mem_q;

  assign ctrl_wr          = io_we && (io_addr == eac_pkg::ADDR_CTRL);
  assign master_write_arm = (st_ff.arm_cnt != 3'h0);
  assign mem_q            = mem[st_ff.eeprom_addr_reg];
  // strobe only counts while armed, idle and flash quiet
  assign wr_start = ctrl_wr && io_wdata[eac_pkg::BIT_WRITE_STROBE] && master_write_arm
                    && !st_ff.write_strobe && !flash_selfprog_busy
                    && !sys_rst;  // a strobe under system reset would start the timer with no strobe bit
  assign rd_go    = ctrl_wr && io_wdata[eac_pkg::BIT_READ_STROBE] && !st_ff.write_strobe;

  function automatic logic [7:0] ctrl_byte(input eac_state_t s, input logic arm);
    ctrl_byte = {4'h0, s.ready_irq_enable, arm, s.write_strobe, s.read_strobe};
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.arm_cnt != 3'h0)
      nxt_st.arm_cnt = st_ff.arm_cnt - 3'h1;
    if (st_ff.stall != 3'h0)
      nxt_st.stall = st_ff.stall - 3'h1;
    else
      nxt_st.read_strobe = 1'b0;
    if (tmr_done)
      nxt_st.write_strobe = 1'b0;
    if (io_we)
    begin
      case (io_addr)
        eac_pkg::ADDR_CTRL:
        begin
          nxt_st.ready_irq_enable = io_wdata[eac_pkg::BIT_READY_IRQ_EN];
          if (io_wdata[eac_pkg::BIT_MASTER_ARM] && !io_wdata[eac_pkg::BIT_WRITE_STROBE])
            nxt_st.arm_cnt = eac_pkg::ARM_CYCLES;
        end
        eac_pkg::ADDR_DATA:
          nxt_st.eeprom_data_reg = io_wdata;
        eac_pkg::ADDR_ADDR_LO:
          if (!st_ff.write_strobe)
            nxt_st.eeprom_addr_reg[7:0] = io_wdata;
        eac_pkg::ADDR_ADDR_HI:
          if (!st_ff.write_strobe)
            nxt_st.eeprom_addr_reg[10:8] = io_wdata[2:0];
        default:
          nxt_st.stall = nxt_st.stall;
      endcase
    end
    if (wr_start)
    begin
      nxt_st.write_strobe = 1'b1;
      nxt_st.arm_cnt      = 3'h0;
      nxt_st.wr_addr      = st_ff.eeprom_addr_reg;
      nxt_st.wr_data      = st_ff.eeprom_data_reg;
      nxt_st.stall        = eac_pkg::WR_STALL;
    end
    else if (rd_go)
    begin
      nxt_st.read_strobe     = 1'b1;
      nxt_st.eeprom_data_reg = mem_q;
      nxt_st.stall           = eac_pkg::RD_STALL;
    end
    if (io_re)
    begin
      case (io_addr)
        eac_pkg::ADDR_CTRL:    nxt_st.rdata = ctrl_byte(st_ff, master_write_arm);
        eac_pkg::ADDR_DATA:    nxt_st.rdata = st_ff.eeprom_data_reg;
        eac_pkg::ADDR_ADDR_LO: nxt_st.rdata = st_ff.eeprom_addr_reg[7:0];
        eac_pkg::ADDR_ADDR_HI: nxt_st.rdata = {5'h00, st_ff.eeprom_addr_reg[10:8]};
        default:               nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // system reset spares the write in flight; only power-on clears it
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      st_ff                 <= '0;
      st_ff.eeprom_addr_reg <= eac_pkg::ADDR_RST;
      st_ff.eeprom_data_reg <= eac_pkg::DATA_RST;
    end
    else if (sys_rst)
    begin
      st_ff                  <= nxt_st;
      st_ff.ready_irq_enable <= 1'b0;
      st_ff.arm_cnt          <= 3'h0;
      st_ff.read_strobe      <= 1'b0;
      st_ff.stall            <= 3'h0;
      st_ff.rdata            <= 8'h00;
      st_ff.write_strobe     <= st_ff.write_strobe && !tmr_done;
    end
    else
      st_ff <= nxt_st;
  end

  always_ff @(posedge clk)
  begin
    if (tmr_done)
      mem[st_ff.wr_addr] <= st_ff.wr_data;
  end

  eac_wr_timer #(
    .OSC_DIV    (OSC_DIV),
    .OSC_CYCLES (WR_OSC_CYC)
  ) u_tmr (
    .clk   (clk),
    .por   (por),
    .start (wr_start),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  assign io_rdata   = st_ff.rdata;
  assign cpu_stall  = (st_ff.stall != 3'h0);
  assign ready_irq  = st_ff.ready_irq_enable && global_irq_en && !st_ff.write_strobe;
  // the oscillator must run on through a power-down request until the write lands
  assign osc_run    = tmr_busy;
  assign pd_allowed = sleep_pd_req && !tmr_busy;

  sequence s_arm_then_quiet;
    (ctrl_wr && io_wdata[2] && !io_wdata[1]) ##1 (!ctrl_wr)[*4];
  endsequence
  sequence s_stall2;
    cpu_stall[*2] ##1 !cpu_stall;
  endsequence
  sequence s_stall4;
    cpu_stall[*4] ##1 !cpu_stall;
  endsequence

  property p_rsvd;
    @(posedge clk) disable iff (por || sys_rst) (io_re && io_addr == eac_pkg::ADDR_CTRL) |=> io_rdata[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits read nonzero");

  property p_irq;
    @(posedge clk) disable iff (por) ready_irq == (st_ff.ready_irq_enable && global_irq_en && !st_ff.write_strobe);
  endproperty
  a_irq: assert property (p_irq) else $error("ready interrupt wrong");

  property p_start;
    @(posedge clk) disable iff (por || sys_rst) wr_start |=> st_ff.write_strobe && tmr_busy;
  endproperty
  a_start: assert property (p_start) else $error("armed strobe did not start write");

  property p_ignore;
    @(posedge clk) disable iff (por || sys_rst)
      (ctrl_wr && io_wdata[1] && !master_write_arm && !st_ff.write_strobe) |=> !st_ff.write_strobe;
  endproperty
  a_ignore: assert property (p_ignore) else $error("unarmed strobe started write");

  property p_arm_expire;
    @(posedge clk) disable iff (por || sys_rst) s_arm_then_quiet |=> !master_write_arm;
  endproperty
  a_arm_expire: assert property (p_arm_expire) else $error("arm bit did not expire");

  property p_flash;
    @(posedge clk) disable iff (por || sys_rst)
      (ctrl_wr && io_wdata[1] && flash_selfprog_busy && !st_ff.write_strobe) |=> !st_ff.write_strobe;
  endproperty
  a_flash: assert property (p_flash) else $error("write started during flash programming");

  property p_done;
    @(posedge clk) disable iff (por) tmr_done |=> !st_ff.write_strobe;
  endproperty
  a_done: assert property (p_done) else $error("write strobe not cleared at end");

  property p_stall_wr;
    @(posedge clk) disable iff (por || sys_rst) wr_start |=> s_stall2;
  endproperty
  a_stall_wr: assert property (p_stall_wr) else $error("write stall not two cycles");

  property p_rd_data;
    @(posedge clk) disable iff (por || sys_rst) (rd_go && !wr_start) |=> st_ff.eeprom_data_reg == $past(mem_q);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not loaded");

  property p_stall_rd;
    @(posedge clk) disable iff (por || sys_rst) (rd_go && !wr_start) |=> s_stall4;
  endproperty
  a_stall_rd: assert property (p_stall_rd) else $error("read stall not four cycles");

  property p_addr_hold;
    @(posedge clk) disable iff (por) st_ff.write_strobe && !tmr_done |=> $stable(st_ff.eeprom_addr_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed during write");

  property p_rs_clear;
    @(posedge clk) disable iff (por || sys_rst) (rd_go && !wr_start) |=> ##5 !st_ff.read_strobe;
  endproperty
  a_rs_clear: assert property (p_rs_clear) else $error("read strobe did not clear");

  property p_rst_keep;
    @(posedge clk) disable iff (por) (sys_rst && st_ff.write_strobe && !tmr_done) |=> st_ff.write_strobe;
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("system reset aborted a write");
endmodule

// [inc/eac_pkg.sv]
// constants for the eeprom access control block
package eac_pkg;
  // i/o space locations (byte registers)
  localparam logic [5:0] ADDR_CTRL    = 6'h1C;
  localparam logic [5:0] ADDR_DATA    = 6'h1D;
  localparam logic [5:0] ADDR_ADDR_LO = 6'h1E;
  localparam logic [5:0] ADDR_ADDR_HI = 6'h1F;
  // control register bit positions
  localparam int BIT_READ_STROBE  = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_MASTER_ARM   = 2;
  localparam int BIT_READY_IRQ_EN = 3;
  // widths and reset values
  localparam int          ADDR_W     = 11;
  localparam int          DATA_W     = 8;
  localparam logic [10:0] ADDR_RST   = 11'h000;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  // timing
  localparam logic [2:0]  ARM_CYCLES = 3'h4;
  localparam logic [2:0]  WR_STALL   = 3'h2;
  localparam logic [2:0]  RD_STALL   = 3'h4;
  localparam int          CLK_HZ     = 10000000;
  localparam int          OSC_HZ     = 1000000;
  localparam int          OSC_DIV    = CLK_HZ / OSC_HZ;
  localparam int          WR_OSC_CYC = 8448;
  localparam int          WR_TIME_US = 8400;
endpackage

// [design/eac_wr_timer.sv]
// write duration timer clocked from a divided reference standing in for the rc oscillator
`timescale 1ns/1ps
module eac_wr_timer #(
  parameter int OSC_DIV    = eac_pkg::OSC_DIV,
  parameter int OSC_CYCLES = eac_pkg::WR_OSC_CYC
) (
  // clock and power-on reset only; system reset must not abort a write
  input  wire logic clk,
  input  wire logic por,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [15:0] pre;
    logic [15:0] cnt;
  } eac_tmr_t;

  eac_tmr_t st_ff;
  eac_tmr_t nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (st_ff.busy)
    begin
      if (st_ff.pre == 16'(OSC_DIV - 1))
      begin
        nxt_st.pre = 16'h0000;
        if (st_ff.cnt == 16'(OSC_CYCLES - 1))
        begin
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end
      else
      begin
        nxt_st.pre = st_ff.pre + 16'h0001;
      end
    end
    else if (start)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.pre  = 16'h0000;
      nxt_st.cnt  = 16'h0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (por)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;
endmodule

// [dv/eeprom_access_control_bench.sv]
// self-checking bench for the eeprom access control block
`timescale 1ns/1ps
module eeprom_access_control_bench;
  localparam int DIV    = 2;
  localparam int OSC_N  = 40;
  localparam int WR_CYC = DIV * OSC_N;
  localparam logic [5:0] CTRL = eac_pkg::ADDR_CTRL;
  localparam logic [5:0] DATA = eac_pkg::ADDR_DATA;
  localparam logic [5:0] A_LO = eac_pkg::ADDR_ADDR_LO;
  localparam logic [5:0] A_HI = eac_pkg::ADDR_ADDR_HI;
  // clock and resets
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       por = 1'b1;
  // cpu side
  logic [5:0] io_addr = 6'h00;
  logic       io_we = 1'b0;
  logic       io_re = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic       global_irq_en = 1'b0;
  logic       flash_selfprog_busy = 1'b0;
  logic       sleep_pd_req = 1'b0;
  logic       cpu_stall;
  logic       ready_irq;
  logic       osc_run;
  logic       pd_allowed;
  int         err_total = 0;
  int         n_tests = 0;
  int         cyc = 0;
  logic [7:0] rd_val;

  eac_ctrl #(.OSC_DIV(DIV), .WR_OSC_CYC(OSC_N), .DEPTH(2048)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .por(por), .io_addr(io_addr), .io_we(io_we), .io_re(io_re),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_en(global_irq_en),
    .flash_selfprog_busy(flash_selfprog_busy), .sleep_pd_req(sleep_pd_req), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq), .osc_run(osc_run), .pd_allowed(pd_allowed)
  );

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(posedge clk) #1;
    io_we = 1'b0;
  endtask

  task automatic io_rd(input logic [5:0] a);
    @(posedge clk) #1;
    io_addr = a;
    io_re = 1'b1;
    @(posedge clk) #1;
    io_re = 1'b0;
    rd_val = io_rdata;
  endtask

  // counts stall cycles from the edge that took the strobe; capped so a stuck stall cannot hang
  task automatic stall_len(output int n);
    n = 0;
    while (cpu_stall === 1'b1 && n < 10)
    begin
      n++;
      @(posedge clk) #1;
    end
  endtask

  task automatic t_ctrl_and_irq;
    io_rd(CTRL);
    check("ctrl_rst", rd_val, 8'h00);
    io_wr(CTRL, 8'hF0);
    io_rd(CTRL);
    check("ctrl_resv", rd_val, 8'h00);
    io_rd(6'h00);
    check("unmapped", rd_val, 8'h00);
    io_wr(CTRL, 8'h08);
    #1;
    check("irq_glob_off", {7'h00, ready_irq}, 8'h00);
    global_irq_en = 1'b1;
    #1;
    check("irq_on", {7'h00, ready_irq}, 8'h01);
    io_wr(CTRL, 8'h00);
    check("irq_off", {7'h00, ready_irq}, 8'h00);
    global_irq_en = 1'b0;
  endtask

  task automatic t_refused_strobes;
    io_wr(CTRL, 8'h02);
    check("no_arm", {7'h00, osc_run}, 8'h00);
    io_wr(CTRL, 8'h04);
    io_rd(CTRL);
    check("armed", rd_val, 8'h04);
    repeat (4) @(posedge clk);
    io_wr(CTRL, 8'h02);
    check("late_strobe", {7'h00, osc_run}, 8'h00);
    io_rd(CTRL);
    check("arm_expired", rd_val, 8'h00);
    flash_selfprog_busy = 1'b1;
    io_wr(CTRL, 8'h04);
    io_wr(CTRL, 8'h02);
    check("flash_block", {7'h00, osc_run}, 8'h00);
    flash_selfprog_busy = 1'b0;
  endtask

  task automatic t_write;
    int n;
    int t0;
    io_wr(A_HI, 8'hFF);
    io_wr(A_LO, 8'hFF);
    io_wr(DATA, 8'hA5);
    io_rd(A_HI);
    check("addr_hi", rd_val, 8'h07);
    sleep_pd_req = 1'b1;
    io_wr(CTRL, 8'h0C);
    io_wr(CTRL, 8'h0A);
    global_irq_en = 1'b1;
    t0 = cyc;
    stall_len(n);
    check("wr_stall", 8'(n), 8'h02);
    check("wr_start", {6'h00, osc_run, ready_irq}, 8'h02);
    io_rd(CTRL);
    check("strobe_held", rd_val, 8'h0A);
    check("pd_hold", {7'h00, pd_allowed}, 8'h00);
    io_wr(CTRL, 8'h09);
    io_wr(A_LO, 8'h12);
    io_rd(DATA);
    check("rd_refused", rd_val, 8'hA5);
    io_rd(A_LO);
    check("addr_locked", rd_val, 8'hFF);
    sys_rst = 1'b1;
    @(posedge clk) #1;
    sys_rst = 1'b0;
    io_rd(CTRL);
    check("rst_keeps_wr", rd_val, 8'h02);
    n = 0;
    while (osc_run === 1'b1 && n < 4 * WR_CYC)
    begin
      @(posedge clk) #1;
      n++;
    end
    if (osc_run !== 1'b0)
    begin
      check("wr_timeout", 8'h01, 8'h00);
      report_and_stop;
    end
    check("wr_len", {7'h00, (cyc - t0 >= WR_CYC - 1) && (cyc - t0 <= WR_CYC + 2)}, 8'h01);
    check("pd_after", {7'h00, pd_allowed}, 8'h01);
    sleep_pd_req = 1'b0;
    io_rd(CTRL);
    check("strobe_clr", rd_val, 8'h00);
    io_wr(CTRL, 8'h08);
    check("irq_after_wr", {7'h00, ready_irq}, 8'h01);
  endtask

  task automatic t_read;
    int n;
    io_wr(DATA, 8'h3C);
    io_wr(CTRL, 8'h01);
    stall_len(n);
    check("rd_stall", 8'(n), 8'h04);
    io_rd(DATA);
    check("rd_data", rd_val, 8'hA5);
    io_rd(CTRL);
    check("rd_strobe_clr", rd_val, 8'h00);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    por = 1'b0;
    t_ctrl_and_irq;
    t_refused_strobes;
    t_write;
    t_read;
    report_and_stop;
  end
endmodule
